// file: neg_partner_model.sv
/* Negotiation partner model: completion flag, partner pause bits and
   the last advertisement word sent. Assumes the bank's pclk. */
`timescale 1ns/1ps
module neg_partner_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench requests
  input  wire logic        done_req,
  input  wire logic        sym_req,
  input  wire logic        asym_req,
  // Link side
  input  wire logic [15:0] advert_word,
  output logic             neg_complete,
  output logic             partner_sym_pause,
  output logic             partner_asym_pause,
  output logic      [15:0] sent_word
);
  logic [15:0] last_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_complete       <= 1'b0;
      partner_sym_pause  <= 1'b0;
      partner_asym_pause <= 1'b0;
      sent_word          <= 16'h0000;
      last_q             <= 16'h0000;
    end else begin
      partner_sym_pause  <= sym_req;
      partner_asym_pause <= asym_req;
      last_q             <= advert_word;
      neg_complete       <= done_req && (advert_word == last_q);
      if (done_req)
        sent_word <= advert_word;
    end
  end
endmodule : neg_partner_model

// file: phy_id_and_an_advert_regs.sv
/*
  Identifier and negotiation advertisement register bank behind an APB
  slave port. Also serves the negotiation-complete status bit, the
  upper identifier word and the pause resolution result.
  Assumes the negotiation engine runs on pclk; strap pins are
  asynchronous and settle before reset is released.
*/
`timescale 1ns/1ps

// What this block does
// - Identifier low bits 15:10 carry vendor code
// - Fixed model number in identifier bits 9:4
// - Fixed revision number in identifier bits 3:0
// - Advertisement register drives negotiation ability word
// - Next page request bit, read-write, reset 0
// - Bit 14 ignores writes, reads zero
// - Remote fault advertise bit, read-write, reset 0
// - Bit 12 reserved, reads zero, reset zero
// - Asymmetric pause advertise bit, read-write, reset 0
// - Symmetric pause advertise bit, read-write, reset 0
// - Pause resolution shown in control bits 13:12
// - Bit 9 reads zero, T4 never advertised
// - Ability bits 8:5 writable, reset to zero, then loaded from straps
// - Selector field writable, resets to 00001
// - Identifier high word carries vendor code bits
// - Status bit 5 shows negotiation complete
module phy_id_and_an_advert_regs #(
  parameter logic [21:0] VENDOR_CODE = 22'h2A5A5, // Arbitrary value
  parameter logic [5:0]  MODEL_NUM   = 6'h2B,     // Arbitrary value
  parameter logic [3:0]  REVISION    = 4'h5       // Arbitrary value
) (
  // Clock and reset
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  // APB slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [phy_regs_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // Strap pins for ability bits 8:5
  input  wire logic [3:0]                         strap_ability,
  // Negotiation engine
  input  wire logic                               neg_complete,
  input  wire logic                               partner_sym_pause,
  input  wire logic                               partner_asym_pause,
  output logic      [15:0]                        advert_word
);
  import phy_regs_pkg::*;

  strap_state_t      state_q;
  strap_state_t      state_d;
  logic [3:0]        strap_meta_q;
  logic [3:0]        strap_sync_q;
  logic [15:0]       advert_q;
  logic [15:0]       advert_d;
  logic [1:0]        pause_res_q;
  logic [1:0]        pause_res_d;
  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic              pslverr_d;
  wire logic [15:0]  id_high_w;
  wire logic [15:0]  id_low_w;
  logic [IDX_W-1:0]  idx;
  logic              aligned;
  logic              hit;
  logic              hit_adv;
  logic [15:0]       rd_word;
  logic              xfer_done;

  assign idx       = paddr[APB_ADDR_W-1:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign xfer_done = psel & penable & pready_q;

  // Vendor code bits 3..24 live in VENDOR_CODE[0..21], first bit at the top
  for (genvar i = 0; i < 16; i++) begin : g_id_high
    assign id_high_w[15-i] = VENDOR_CODE[i];
  end
  for (genvar j = 0; j < 6; j++) begin : g_id_low
    assign id_low_w[15-j] = VENDOR_CODE[16+j];
  end
  assign id_low_w[9:4] = MODEL_NUM;
  assign id_low_w[3:0] = REVISION;

  // Strap synchroniser: first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta_q <= 4'h0;
      strap_sync_q <= 4'h0;
    end else begin
      strap_meta_q <= strap_ability;
      strap_sync_q <= strap_meta_q;
    end
  end

  // Bus stays stalled until the straps have been loaded
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_FILL1: state_d = S_FILL2;
      S_FILL2: state_d = S_LOAD;
      S_LOAD:  state_d = S_RUN;
      S_RUN:   state_d = S_RUN;
      default: state_d = S_FILL1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_FILL1;
    end else begin
      state_q <= state_d;
    end
  end

  // Address decode and read mux
  always_comb begin
    hit     = 1'b0;
    hit_adv = 1'b0;
    rd_word = 16'h0000;
    if (!aligned) begin
      hit = 1'b0;
    end else if (idx == IDX_BASIC_STATUS) begin
      hit = 1'b1;
      rd_word[STAT_NEG_DONE] = neg_complete;
    end else if (idx == IDX_ID_HIGH) begin
      hit     = 1'b1;
      rd_word = id_high_w;
    end else if (idx == IDX_ID_LOW) begin
      hit     = 1'b1;
      rd_word = id_low_w;
    end else if (idx == IDX_ADVERT) begin
      hit     = 1'b1;
      hit_adv = 1'b1;
      rd_word = advert_q;
    end else if (idx == IDX_PHY_CONTROL) begin
      hit = 1'b1;
      rd_word[CTRL_PAUSE_LO+1:CTRL_PAUSE_LO] = pause_res_q;
    end
  end

  // Answer one cycle into the access phase, with data and error together
  always_comb begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (psel && penable && !pready_q && state_q == S_RUN) begin
      pready_d  = 1'b1;
      pslverr_d = ~hit;
      prdata_d  = 32'h0000_0000;
      if (!pwrite) begin
        prdata_d = {16'h0000, rd_word};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // Advertisement register; reserved and T4 bits are never stored
  always_comb begin
    advert_d = advert_q;
    if (state_q == S_LOAD) begin
      advert_d[ADV_ABIL_HI:ADV_ABIL_LO] = strap_sync_q;
    end else if (xfer_done && pwrite && hit_adv) begin
      advert_d = pwdata[15:0] & ADV_WRITE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      advert_q <= ADV_RESET;
    end else begin
      advert_q <= advert_d;
    end
  end

  // Pause resolution; held at zero until negotiation has finished
  always_comb begin
    pause_res_d = 2'b00;
    if (neg_complete) begin
      pause_res_d[1] = (advert_q[ADV_SYM_PAUSE] & partner_sym_pause) |
                       (~advert_q[ADV_SYM_PAUSE] & advert_q[ADV_ASYM_PAUSE] &
                        partner_sym_pause & partner_asym_pause);
      pause_res_d[0] = (advert_q[ADV_SYM_PAUSE] & partner_sym_pause) |
                       (advert_q[ADV_SYM_PAUSE] & advert_q[ADV_ASYM_PAUSE] &
                        ~partner_sym_pause & partner_asym_pause);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_res_q <= 2'b00;
    end else begin
      pause_res_q <= pause_res_d;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign advert_word = advert_q;

  chk_id_low_vendor: assert property (@(posedge pclk) disable iff (!presetn)
    (pready_q && $past(!pwrite && aligned && idx == IDX_ID_LOW))
    |-> prdata_q[15:10] == {VENDOR_CODE[16], VENDOR_CODE[17], VENDOR_CODE[18],
                            VENDOR_CODE[19], VENDOR_CODE[20], VENDOR_CODE[21]})
    else $error("identifier low vendor bits wrong");

  chk_id_low_rev: assert property (@(posedge pclk) disable iff (!presetn)
    (pready_q && $past(!pwrite && aligned && idx == IDX_ID_LOW))
    |-> prdata_q[9:0] == {MODEL_NUM, REVISION})
    else $error("model or revision field wrong");

  chk_advert_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (pready_q && $past(!pwrite && hit_adv)) |-> prdata_q[15:0] == advert_word)
    else $error("advertisement readback differs from ability word");

  chk_next_page_wr: assert property (@(posedge pclk) disable iff (!presetn)
    (xfer_done && pwrite && hit_adv)
    |=> advert_word[ADV_NEXT_PAGE] == $past(pwdata[ADV_NEXT_PAGE])
        && advert_word[ADV_REMOTE_FLT] == $past(pwdata[ADV_REMOTE_FLT]))
    else $error("next page or remote fault not written");

  chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    xfer_done ##1 1'b1 |-> advert_word[ADV_RSVD_IEEE] == 1'b0)
    else $error("reserved bit 14 not zero");

  chk_future_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (xfer_done && pwrite && hit_adv && pwdata[ADV_RSVD_FUTURE])
    |=> !advert_word[ADV_RSVD_FUTURE])
    else $error("reserved bit 12 stored a write");

  chk_t4_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (xfer_done && pwrite && hit_adv) |=> !advert_word[ADV_T4])
    else $error("T4 ability advertised");

  chk_strap_load: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_LOAD) |=> advert_word[ADV_ABIL_HI:ADV_ABIL_LO] == $past(strap_sync_q)
                            && advert_word[ADV_SEL_HI:0] == 5'h01)
    else $error("strap ability bits not loaded");

  chk_pause_both: assert property (@(posedge pclk) disable iff (!presetn)
    (neg_complete && advert_q[ADV_SYM_PAUSE] && partner_sym_pause)
    |=> pause_res_q == 2'b11)
    else $error("symmetric pause not resolved");

  chk_status_done: assert property (@(posedge pclk) disable iff (!presetn)
    (pready_q && $past(!pwrite && aligned && idx == IDX_BASIC_STATUS))
    |-> prdata_q[STAT_NEG_DONE] == $past(neg_complete))
    else $error("negotiation complete bit wrong");

  chk_pause_tx_only: assert property (@(posedge pclk) disable iff (!presetn)
    (neg_complete && !advert_q[ADV_SYM_PAUSE] && advert_q[ADV_ASYM_PAUSE] &&
     partner_sym_pause && partner_asym_pause) |=> pause_res_q == 2'b10)
    else $error("asymmetric pause transmit not resolved");

  chk_pause_rx_only: assert property (@(posedge pclk) disable iff (!presetn)
    (neg_complete && advert_q[ADV_SYM_PAUSE] && advert_q[ADV_ASYM_PAUSE] &&
     !partner_sym_pause && partner_asym_pause) |=> pause_res_q == 2'b01)
    else $error("asymmetric pause receive not resolved");

  chk_pause_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !neg_complete |=> pause_res_q == 2'b00)
    else $error("pause result shown before negotiation done");

  chk_selector_wr: assert property (@(posedge pclk) disable iff (!presetn)
    (xfer_done && pwrite && hit_adv)
    |=> advert_word[ADV_SEL_HI:0] == $past(pwdata[ADV_SEL_HI:0]))
    else $error("selector field not written");

endmodule : phy_id_and_an_advert_regs

// file: phy_regs_pkg.sv
/*
  Shared constants for the identifier and advertisement register bank:
  register indices, field positions, reset values and write masks.
  Assumes an APB slave with 32-bit data, one register per aligned word,
  byte address equal to four times the register index.
*/
package phy_regs_pkg;

  // Bus geometry
  localparam int          APB_ADDR_W      = 8;
  localparam int          IDX_W           = APB_ADDR_W - 2;

  // Register indices (byte address = 4 * index)
  localparam logic [5:0]  IDX_BASIC_STATUS = 6'h01;
  localparam logic [5:0]  IDX_ID_HIGH      = 6'h02;
  localparam logic [5:0]  IDX_ID_LOW       = 6'h03;
  localparam logic [5:0]  IDX_ADVERT       = 6'h04;
  localparam logic [5:0]  IDX_PHY_CONTROL  = 6'h10;

  // Advertisement field positions
  localparam int          ADV_NEXT_PAGE   = 15;
  localparam int          ADV_RSVD_IEEE   = 14;
  localparam int          ADV_REMOTE_FLT  = 13;
  localparam int          ADV_RSVD_FUTURE = 12;
  localparam int          ADV_ASYM_PAUSE  = 11;
  localparam int          ADV_SYM_PAUSE   = 10;
  localparam int          ADV_T4          = 9;
  localparam int          ADV_ABIL_HI     = 8;
  localparam int          ADV_ABIL_LO     = 5;
  localparam int          ADV_SEL_HI      = 4;

  // Advertisement reset value and writable bits
  localparam logic [15:0] ADV_RESET       = 16'h0001;
  localparam logic [15:0] ADV_WRITE_MASK  = 16'hADFF;

  // Status and control field positions
  localparam int          STAT_NEG_DONE   = 5;
  localparam int          CTRL_PAUSE_LO   = 12;

  // Strap pins pass two flops before they are loaded
  localparam int          STRAP_SYNC_CYC  = 2;

  typedef enum logic [3:0] {
    S_FILL1 = 4'b0001,
    S_FILL2 = 4'b0010,
    S_LOAD  = 4'b0100,
    S_RUN   = 4'b1000
  } strap_state_t;

endpackage : phy_regs_pkg

// file: tb_phy_id_and_an_advert_regs.sv
/* Self-checking bench for the identifier and advertisement bank.
   Assumes a 20 MHz pclk and the negotiation partner model. */
`timescale 1ns/1ps
module tb_phy_id_and_an_advert_regs;
  import phy_regs_pkg::*;
  localparam logic [21:0] VC = 22'h15A3C; // Arbitrary value
  localparam logic [5:0]  MN = 6'h19;     // Arbitrary value
  localparam logic [3:0]  RV = 4'h6;      // Arbitrary value
  typedef struct {logic w; logic [7:0] a; logic [15:0] d; logic [31:0] r; logic e;} row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, gerr;
  logic        done_req, sym_req, asym_req, neg_complete, psym, pasym;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, got;
  logic [3:0]  straps;
  logic [15:0] advert_word, sent_word, idlo, idhi;
  logic [5:0]  pz [4];
  row_t        rows [12];
  int          fails, total_checks;

  phy_id_and_an_advert_regs #(.VENDOR_CODE(VC), .MODEL_NUM(MN), .REVISION(RV)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_ability(straps), .neg_complete(neg_complete),
    .partner_sym_pause(psym), .partner_asym_pause(pasym), .advert_word(advert_word));
  neg_partner_model partner_u (
    .pclk(pclk), .presetn(presetn), .done_req(done_req), .sym_req(sym_req),
    .asym_req(asym_req), .advert_word(advert_word), .neg_complete(neg_complete),
    .partner_sym_pause(psym), .partner_asym_pause(pasym), .sent_word(sent_word));

  // Vendor code bits run reversed against register bit order
  always_comb begin
    for (int i = 0; i < 16; i++) idhi[15-i] = VC[i];
    for (int i = 0; i < 6; i++) idlo[15-i] = VC[16+i];
    idlo[9:0] = {MN, RV};
  end

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic results();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  // Leaves the bus held after the answer so a setup may follow at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      results();
    end
    got  = prdata;
    gerr = pslverr;
  endtask : apb

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : idle

  initial begin
    {presetn, psel, penable, pwrite, done_req, sym_req, asym_req} = 7'h00;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    straps = 4'hA;
    fails = 0;
    total_checks = 0;
    pz = '{6'b10_01_11, 6'b11_10_10, 6'b01_11_01, 6'b11_00_00};
    repeat (10) @(posedge pclk);
    check({16'h0000, advert_word}, 32'h0000_0001);
    rows[0]  = '{1'b0, 8'h10, 16'h0000, 32'h0000_0141, 1'b0};
    rows[1]  = '{1'b1, 8'h10, 16'hFFFF, 32'h0000_0000, 1'b0};
    rows[2]  = '{1'b0, 8'h10, 16'h0000, 32'h0000_ADFF, 1'b0};
    rows[3]  = '{1'b1, 8'h0C, 16'hFFFF, 32'h0000_0000, 1'b0};
    rows[4]  = '{1'b0, 8'h0C, 16'h0000, {16'h0000, idlo}, 1'b0};
    rows[5]  = '{1'b0, 8'h08, 16'h0000, {16'h0000, idhi}, 1'b0};
    rows[6]  = '{1'b0, 8'h04, 16'h0000, 32'h0000_0000, 1'b0};
    rows[7]  = '{1'b0, 8'h14, 16'h0000, 32'h0000_0000, 1'b1};
    rows[8]  = '{1'b1, 8'h10, 16'h0000, 32'h0000_0000, 1'b0};
    rows[9]  = '{1'b0, 8'h10, 16'h0000, 32'h0000_0000, 1'b0};
    rows[10] = '{1'b1, 8'h11, 16'hFFFF, 32'h0000_0000, 1'b1};
    rows[11] = '{1'b0, 8'h10, 16'h0000, 32'h0000_0000, 1'b0};
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check(got, rows[i].r);
      check({31'h0, gerr}, {31'h0, rows[i].e});
      idle();
    end
    done_req <= 1'b1;
    foreach (pz[k]) begin
      sym_req  <= pz[k][5];
      asym_req <= pz[k][4];
      apb(1'b1, 8'h10, {4'h0, pz[k][3:2], 10'h001});
      apb(1'b0, 8'h10, 16'h0000);
      check(got, {20'h00000, pz[k][3:2], 10'h001});
      idle();
      repeat (4) @(posedge pclk);
      check({16'h0000, sent_word}, got);
      apb(1'b0, 8'h40, 16'h0000);
      check(got, {18'h00000, pz[k][1:0], 12'h000});
      apb(1'b0, 8'h04, 16'h0000);
      check(got, 32'h0000_0020);
      idle();
    end
    presetn <= 1'b0;
    straps  <= 4'h5;
    @(posedge pclk);
    check({16'h0000, advert_word}, 32'h0000_0001);
    presetn <= 1'b1;
    apb(1'b0, 8'h10, 16'h0000);
    check(got, 32'h0000_00A1);
    idle();
    check({16'h0000, advert_word}, 32'h0000_00A1);
    results();
  end
endmodule : tb_phy_id_and_an_advert_regs
